/* rtl/duct_top.sv */
// duct_top: register slave, command decode, status and test-mode routing
// for the debug uart; the bit engines and dma channel registers sit outside.
// assumes one 125 MHz clock, engines and debug channel flags on that clock.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module duct_top #(
   parameter logic [31:0] CHIP_IDENT_VALUE = 32'h0123_4560, // arbitrary value
   parameter logic [31:0] CHIP_EXT_VALUE   = 32'h0000_00A5  // arbitrary value
) (
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic                      hready,
   input  wire logic [31:0]               hwdata,
   output logic [31:0]                    hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   input  wire logic                      serial_in_pin,
   output logic                           serial_out_pin,
   output duct_pkg::duct_eng_ctl_t        eng_ctl,
   input  wire duct_pkg::duct_eng_evt_t   eng_evt,
   output logic                           rx_dma_req,
   output logic                           tx_dma_req,
   input  wire duct_pkg::duct_dma_status_t dma_status,
   output logic [3:0]                     dma_rd_index,
   input  wire logic [31:0]               dma_rdata,
   output duct_pkg::duct_dma_write_t      dma_write,
   input  wire logic                      dbg_to_cpu_pending,
   input  wire logic                      cpu_to_dbg_pending,
   output logic                           irq
);

   function automatic duct_pkg::duct_parity_t decode_parity(input logic [2:0] f);
      duct_pkg::duct_parity_t p;
      p.enable     = ~f[2];
      p.forced     = f[1];
      p.odd_or_one = f[0];
      return p;
   endfunction

   function automatic logic in_dma_window(input logic [11:0] a);
      return (a >= duct_pkg::OFF_DMA_FIRST) && (a <= duct_pkg::OFF_DMA_LAST);
   endfunction

   // bus capture
   logic        acc;
   logic        wr_pend;
   logic [11:0] wr_addr;
   logic        rd_take;

   // configuration and state
   logic [1:0]  channel_test_mode;
   logic [2:0]  parity_type;
   logic [15:0] baud_cd;
   logic [31:0] irq_mask;
   logic        receiver_on;
   logic        transmitter_on;
   logic        rx_char_ready;
   logic [7:0]  rx_holding;
   logic        overrun_flag;
   logic        framing_flag;
   logic        parity_error_flag;
   logic        tx_hold_full;
   logic [7:0]  tx_holding;
   logic        rx_pin_meta;
   logic        rx_pin_sync;

   // data phase write strobes
   logic        wr_ctrl;
   logic        wr_mode;
   logic        wr_ier;
   logic        wr_idr;
   logic        wr_thr;
   logic        wr_baud;
   logic        rd_rhr;
   logic        receiver_reset;
   logic        transmitter_reset;
   logic        clear_error_flags;
   logic        remote_mode;
   logic        tx_holding_free;
   logic        tx_empty;
   logic [31:0] line_status;
   logic [31:0] next_rdata;

   assign acc     = hsel & htrans[1] & hready;
   assign rd_take = acc & ~hwrite;

   assign wr_ctrl = wr_pend && (wr_addr == duct_pkg::OFF_CONTROL_COMMAND);
   assign wr_mode = wr_pend && (wr_addr == duct_pkg::OFF_MODE_CONFIG);
   assign wr_ier  = wr_pend && (wr_addr == duct_pkg::OFF_IRQ_ENABLE_SET);
   assign wr_idr  = wr_pend && (wr_addr == duct_pkg::OFF_IRQ_ENABLE_CLEAR);
   assign wr_thr  = wr_pend && (wr_addr == duct_pkg::OFF_TX_HOLDING);
   assign wr_baud = wr_pend && (wr_addr == duct_pkg::OFF_BAUD_DIVISOR);
   assign rd_rhr  = rd_take && (haddr[11:0] == duct_pkg::OFF_RX_HOLDING);

   // writing zero to any command bit leaves everything alone
   assign receiver_reset    = wr_ctrl & hwdata[duct_pkg::CTL_RECEIVER_RESET];
   assign transmitter_reset = wr_ctrl & hwdata[duct_pkg::CTL_TRANSMITTER_RESET];
   assign clear_error_flags = wr_ctrl & hwdata[duct_pkg::CTL_CLEAR_ERROR_FLAGS];

   assign remote_mode = (channel_test_mode == duct_pkg::CM_REMOTE);

   // zero wait state slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
      end else begin
         wr_pend <= acc & hwrite;
         if (acc) begin
            wr_addr <= haddr[11:0];
         end
      end
   end

   // pin synchroniser
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_pin_meta <= 1'b1;
         rx_pin_sync <= 1'b1;
      end else begin
         rx_pin_meta <= serial_in_pin;
         rx_pin_sync <= rx_pin_meta;
      end
   end

   // mode_config and baud_divisor
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         channel_test_mode <= duct_pkg::CHANNEL_TEST_MODE_RESET;
         parity_type       <= duct_pkg::PARITY_RESET;
         baud_cd           <= duct_pkg::BAUD_RESET;
      end else begin
         if (wr_mode) begin
            channel_test_mode <= hwdata[duct_pkg::MODE_CHANNEL_TEST_MODE_LSB +: 2];
            parity_type       <= hwdata[duct_pkg::MODE_PARITY_LSB +: 3];
         end
         if (wr_baud) begin
            baud_cd <= hwdata[15:0];
         end
      end
   end

   // interrupt mask: set and clear registers, only implemented sources
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask <= duct_pkg::MASK_RESET;
      end else if (wr_ier) begin
         irq_mask <= irq_mask | (hwdata & duct_pkg::MASK_IMPLEMENTED);
      end else if (wr_idr) begin
         irq_mask <= irq_mask & ~hwdata;
      end
   end

   // receiver enable; reset then enable in one write leaves it enabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         receiver_on <= 1'b0;
      end else if (wr_ctrl) begin
         if (hwdata[duct_pkg::CTL_RECEIVER_OFF]) begin
            receiver_on <= 1'b0;
         end else if (hwdata[duct_pkg::CTL_RECEIVER_ON]) begin
            receiver_on <= 1'b1;
         end else if (hwdata[duct_pkg::CTL_RECEIVER_RESET]) begin
            receiver_on <= 1'b0;
         end
      end
   end

   // transmitter enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         transmitter_on <= 1'b0;
      end else if (wr_ctrl) begin
         if (hwdata[duct_pkg::CTL_TRANSMITTER_OFF]) begin
            transmitter_on <= 1'b0;
         end else if (hwdata[duct_pkg::CTL_TRANSMITTER_ON]) begin
            transmitter_on <= 1'b1;
         end else if (hwdata[duct_pkg::CTL_TRANSMITTER_RESET]) begin
            transmitter_on <= 1'b0;
         end
      end
   end

   // receive holding and ready: a new character wins over the read that clears
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_char_ready <= 1'b0;
         rx_holding    <= duct_pkg::RX_HOLDING_RESET;
      end else begin
         if (eng_evt.rx_valid) begin
            rx_char_ready <= 1'b1;
            rx_holding    <= eng_evt.rx_data;
         end else if (rd_rhr || receiver_reset) begin
            rx_char_ready <= 1'b0;
         end
      end
   end

   // error flags, set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         overrun_flag      <= 1'b0;
         framing_flag      <= 1'b0;
         parity_error_flag <= 1'b0;
      end else begin
         if (eng_evt.rx_valid && rx_char_ready && !rd_rhr) begin
            overrun_flag <= 1'b1;
         end else if (clear_error_flags) begin
            overrun_flag <= 1'b0;
         end
         if (eng_evt.rx_valid && eng_evt.rx_frame_err) begin
            framing_flag <= 1'b1;
         end else if (clear_error_flags) begin
            framing_flag <= 1'b0;
         end
         if (eng_evt.rx_valid && eng_evt.rx_parity_err) begin
            parity_error_flag <= 1'b1;
         end else if (clear_error_flags) begin
            parity_error_flag <= 1'b0;
         end
      end
   end

   // transmit holding: a write in the take cycle stays pending as the next char
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_hold_full <= 1'b0;
         tx_holding   <= 8'h00;
      end else begin
         if (wr_thr && transmitter_on) begin
            tx_hold_full <= 1'b1;
            tx_holding   <= hwdata[7:0];
         end else if (transmitter_reset || eng_evt.tx_take) begin
            tx_hold_full <= 1'b0;
         end
      end
   end

   assign tx_holding_free = transmitter_on & ~tx_hold_full;
   assign tx_empty        = tx_holding_free & ~eng_evt.tx_busy;

   assign rx_dma_req = rx_char_ready;
   assign tx_dma_req = tx_holding_free;

   // engine control; a disabled transmitter drains the character in hand, a disabled receiver stops at once
   always_comb begin
      eng_ctl.rx_run        = receiver_on & ~remote_mode;
      eng_ctl.rx_abort      = receiver_reset;
      eng_ctl.tx_run        = (transmitter_on | tx_hold_full | eng_evt.tx_busy)
                              & ~remote_mode;
      eng_ctl.tx_abort      = transmitter_reset;
      eng_ctl.tx_load_valid = tx_hold_full & ~remote_mode;
      eng_ctl.tx_data       = tx_holding;
      eng_ctl.parity        = decode_parity(parity_type);
      eng_ctl.baud_cd       = baud_cd;
      case (channel_test_mode)
         duct_pkg::CM_LOCAL:  eng_ctl.rx_line = eng_evt.tx_line;
         duct_pkg::CM_REMOTE: eng_ctl.rx_line = 1'b1;
         default:             eng_ctl.rx_line = rx_pin_sync;
      endcase
   end

   // serial output, registered so the pin never glitches on mode changes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serial_out_pin <= 1'b1;
      end else begin
         case (channel_test_mode)
            duct_pkg::CM_NORMAL: serial_out_pin <= eng_evt.tx_line;
            duct_pkg::CM_ECHO:   serial_out_pin <= rx_pin_sync;
            duct_pkg::CM_LOCAL:  serial_out_pin <= 1'b1;
            duct_pkg::CM_REMOTE: serial_out_pin <= rx_pin_sync;
            default:             serial_out_pin <= 1'b1;
         endcase
      end
   end

   always_comb begin
      line_status = 32'h0000_0000;
      line_status[duct_pkg::ST_RX_CHAR_READY]   = rx_char_ready;
      line_status[duct_pkg::ST_TX_HOLDING_FREE] = tx_holding_free;
      line_status[duct_pkg::ST_END_RX]          = dma_status.end_rx;
      line_status[duct_pkg::ST_END_TX]          = dma_status.end_tx;
      line_status[duct_pkg::ST_OVERRUN]         = overrun_flag;
      line_status[duct_pkg::ST_FRAMING]         = framing_flag;
      line_status[duct_pkg::ST_PARITY]          = parity_error_flag;
      line_status[duct_pkg::ST_TX_EMPTY]        = tx_empty;
      line_status[duct_pkg::ST_TX_BUF_EMPTY]    = dma_status.tx_buf_empty;
      line_status[duct_pkg::ST_RX_BUF_FULL]     = dma_status.rx_buf_full;
      line_status[duct_pkg::ST_CPU_TO_DBG]      = cpu_to_dbg_pending;
      line_status[duct_pkg::ST_DBG_TO_CPU]      = dbg_to_cpu_pending;
   end

   // level interrupt; clearing is by servicing the source
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(line_status & irq_mask);
      end
   end

   // dma channel registers are forwarded into the unit's own window
   assign dma_rd_index = haddr[5:2];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dma_write <= '0;
      end else begin
         dma_write.wr    <= wr_pend && in_dma_window(wr_addr);
         dma_write.index <= 4'(((wr_addr - duct_pkg::OFF_DMA_FIRST) >> 2));
         dma_write.wdata <= hwdata;
      end
   end

   // read mux, evaluated in the address phase
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (haddr[11:0])
         duct_pkg::OFF_MODE_CONFIG: begin
            next_rdata[duct_pkg::MODE_CHANNEL_TEST_MODE_LSB +: 2] = channel_test_mode;
            next_rdata[duct_pkg::MODE_PARITY_LSB +: 3] = parity_type;
         end
         duct_pkg::OFF_IRQ_MASK_VIEW: next_rdata = irq_mask;
         duct_pkg::OFF_LINE_STATUS:   next_rdata = line_status;
         duct_pkg::OFF_RX_HOLDING:    next_rdata = {24'h00_0000, rx_holding};
         duct_pkg::OFF_BAUD_DIVISOR:  next_rdata = {16'h0000, baud_cd};
         duct_pkg::OFF_CHIP_IDENT:    next_rdata = CHIP_IDENT_VALUE;
         duct_pkg::OFF_CHIP_IDENT_EXT: begin
            if (CHIP_IDENT_VALUE[duct_pkg::CHIP_EXT_BIT]) begin
               next_rdata = CHIP_EXT_VALUE;
            end else begin
               next_rdata = 32'h0000_0000;
            end
         end
         default: begin
            if (in_dma_window(haddr[11:0])) begin
               next_rdata = dma_rdata;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_take) begin
         hrdata <= next_rdata;
      end
   end

endmodule

`default_nettype wire

/* rtl/duct_pkg.sv */
// duct_pkg: constants, field layouts and carrier types for the debug uart
// control and test-mode block.
// assumes a 32-bit AHB-Lite register window, byte offsets as listed below.
package duct_pkg;

   localparam logic [11:0] OFF_CONTROL_COMMAND   = 12'h000;
   localparam logic [11:0] OFF_MODE_CONFIG       = 12'h004;
   localparam logic [11:0] OFF_IRQ_ENABLE_SET    = 12'h008;
   localparam logic [11:0] OFF_IRQ_ENABLE_CLEAR  = 12'h00C;
   localparam logic [11:0] OFF_IRQ_MASK_VIEW     = 12'h010;
   localparam logic [11:0] OFF_LINE_STATUS       = 12'h014;
   localparam logic [11:0] OFF_RX_HOLDING        = 12'h018;
   localparam logic [11:0] OFF_TX_HOLDING        = 12'h01C;
   localparam logic [11:0] OFF_BAUD_DIVISOR      = 12'h020;
   localparam logic [11:0] OFF_CHIP_IDENT        = 12'h040;
   localparam logic [11:0] OFF_CHIP_IDENT_EXT    = 12'h044;
   localparam logic [11:0] OFF_DMA_FIRST         = 12'h100;
   localparam logic [11:0] OFF_DMA_LAST          = 12'h124;

   // control_command bits
   localparam int CTL_RECEIVER_RESET    = 2;
   localparam int CTL_TRANSMITTER_RESET = 3;
   localparam int CTL_RECEIVER_ON       = 4;
   localparam int CTL_RECEIVER_OFF      = 5;
   localparam int CTL_TRANSMITTER_ON    = 6;
   localparam int CTL_TRANSMITTER_OFF   = 7;
   localparam int CTL_CLEAR_ERROR_FLAGS = 8;

   // mode_config fields
   localparam int MODE_PARITY_LSB = 9;
   localparam int MODE_CHANNEL_TEST_MODE_LSB = 14;

   // line_status / irq mask bit positions
   localparam int ST_RX_CHAR_READY   = 0;
   localparam int ST_TX_HOLDING_FREE = 1;
   localparam int ST_END_RX          = 3;
   localparam int ST_END_TX          = 4;
   localparam int ST_OVERRUN         = 5;
   localparam int ST_FRAMING         = 6;
   localparam int ST_PARITY          = 7;
   localparam int ST_TX_EMPTY        = 9;
   localparam int ST_TX_BUF_EMPTY    = 11;
   localparam int ST_RX_BUF_FULL     = 12;
   localparam int ST_CPU_TO_DBG      = 30;
   localparam int ST_DBG_TO_CPU      = 31;

   localparam int CHIP_EXT_BIT = 31;

   localparam logic [31:0] MASK_IMPLEMENTED = 32'hC000_1AFB;
   localparam logic [31:0] MASK_RESET       = 32'h0000_0000;
   localparam logic [1:0]  CHANNEL_TEST_MODE_RESET     = 2'h0;
   localparam logic [2:0]  PARITY_RESET     = 3'h0;
   localparam logic [15:0] BAUD_RESET       = 16'h0000;
   localparam logic [7:0]  RX_HOLDING_RESET = 8'h00;

   typedef enum logic [1:0] {
      CM_NORMAL = 2'b00,
      CM_ECHO   = 2'b01,
      CM_LOCAL  = 2'b10,
      CM_REMOTE = 2'b11
   } duct_channel_test_mode_t;

   typedef struct packed {
      logic enable;
      logic forced;
      logic odd_or_one;
   } duct_parity_t;

   // to the bit-level receiver and transmitter engines
   typedef struct packed {
      logic         rx_run;
      logic         rx_abort;
      logic         rx_line;
      logic         tx_run;
      logic         tx_abort;
      logic         tx_load_valid;
      logic [7:0]   tx_data;
      duct_parity_t parity;
      logic [15:0]  baud_cd;
   } duct_eng_ctl_t;

   // from the engines
   typedef struct packed {
      logic       rx_valid;
      logic [7:0] rx_data;
      logic       rx_parity_err;
      logic       rx_frame_err;
      logic       tx_take;
      logic       tx_busy;
      logic       tx_line;
   } duct_eng_evt_t;

   typedef struct packed {
      logic end_rx;
      logic end_tx;
      logic tx_buf_empty;
      logic rx_buf_full;
   } duct_dma_status_t;

   typedef struct packed {
      logic        wr;
      logic [3:0]  index;
      logic [31:0] wdata;
   } duct_dma_write_t;

endpackage

/* tb/duct_checker.sv */
// duct_checker: port-level assertions for duct_top.
// assumes hready tied to hreadyout and one hclk domain.
`timescale 1ns/1ps
`default_nettype none
module duct_checker (
   input wire logic                    hclk,
   input wire logic                    hresetn,
   input wire logic                    hsel,
   input wire logic [31:0]             haddr,
   input wire logic [1:0]              htrans,
   input wire logic                    hwrite,
   input wire logic                    hready,
   input wire logic [31:0]             hwdata,
   input wire logic                    serial_in_pin,
   input wire logic                    serial_out_pin,
   input wire duct_pkg::duct_eng_ctl_t eng_ctl,
   input wire duct_pkg::duct_eng_evt_t eng_evt,
   input wire logic                    rx_dma_req,
   input wire logic                    tx_dma_req
);
   logic        ap_w, pp;
   logic [11:0] ap_a;
   logic [15:0] md;
   logic [2:0]  age;
   logic [3:0]  qt;
   wire logic   act = hsel & htrans[1] & hready;
   wire logic   mw  = ap_w && ap_a == 12'h004;
   wire logic   cw  = ap_w && ap_a == 12'h000;
   // a pin change shows in the sampled pin one edge before pp and qt see it
   wire logic   quiet = qt > 4'h5 && pp == serial_in_pin;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // mode mirror; qt counts quiet cycles so pin checks skip the synchroniser delay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {ap_w, pp, ap_a, md, age, qt} <= '0;
      end else begin
         ap_w <= act & hwrite;
         ap_a <= haddr[11:0];
         pp   <= serial_in_pin;
         md   <= mw ? hwdata[15:0] : md;
         age  <= mw ? 3'h0 : age + 3'(age != 3'h7);
         qt   <= (mw || pp != serial_in_pin) ? 4'h0 : qt + 4'(qt != 4'hF);
      end
   end
   a_rx_req_cause: assert property ($rose(rx_dma_req) |-> $past(eng_evt.rx_valid))
      else $error("receive request without a received character");
   a_tx_req_free: assert property (tx_dma_req |-> !eng_ctl.tx_load_valid)
      else $error("transmit request while a character is pending");
   a_read_clears: assert property (act && !hwrite && haddr[11:0] == 12'h018 && !eng_evt.rx_valid
      |=> !rx_dma_req) else $error("receive ready kept after holding read");
   a_echo_path: assert property (md[15:14] == 2'b01 && quiet |-> serial_out_pin == serial_in_pin)
      else $error("echo mode output differs from input pin");
   a_local_loop: assert property (md[15:14] == 2'b10 && quiet |-> serial_out_pin
      && eng_ctl.rx_line == eng_evt.tx_line) else $error("local loopback routing wrong");
   a_remote_loop: assert property (md[15:14] == 2'b11 && quiet |-> serial_out_pin == serial_in_pin
      && !eng_ctl.rx_run && !eng_ctl.tx_run) else $error("remote loopback routing wrong");
   a_parity_map: assert property (age > 3'h1 |-> eng_ctl.parity.enable == !md[11] && (md[11]
      || {eng_ctl.parity.forced, eng_ctl.parity.odd_or_one} == md[10:9])) else $error("parity decode wrong");
   a_rx_reset: assert property (cw && hwdata[2] && !hwdata[4] |-> eng_ctl.rx_abort ##1 !eng_ctl.rx_run)
      else $error("receiver reset not applied");
   a_tx_reset: assert property (cw && hwdata[3] && !hwdata[6] |-> eng_ctl.tx_abort ##1 !eng_ctl.tx_run)
      else $error("transmitter reset not applied");
   a_rx_on: assert property (cw && hwdata[4] && !hwdata[5] && md[15:14] != 2'b11 |=> eng_ctl.rx_run)
      else $error("receiver not enabled");
   a_rx_off: assert property (cw && hwdata[5] |=> !eng_ctl.rx_run)
      else $error("receiver not disabled");
   a_tx_on: assert property (cw && hwdata[6] && !hwdata[7] && md[15:14] != 2'b11 |=> eng_ctl.tx_run)
      else $error("transmitter not enabled");
   c_rx_reset: cover property (cw && hwdata[2]);
   c_remote: cover property (md[15:14] == 2'b11 && quiet);
   c_rx_char: cover property ($rose(rx_dma_req));
endmodule
`default_nettype wire

/* tb/duct_far_end.sv */
// duct_far_end: stand-in for the bit engines and the line beyond them.
// assumes the bench commands received characters and the idle line level.
`timescale 1ns/1ps
`default_nettype none
module duct_far_end (
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire duct_pkg::duct_eng_ctl_t ctl,
   input  wire logic                    rx_go,
   input  wire logic [9:0]              rx_in,
   input  wire logic                    idle_line,
   input  wire logic [3:0]              delay,
   output duct_pkg::duct_eng_evt_t      evt
);
   logic       rv, tk;
   logic [3:0] cnt, bsy;
   logic [9:0] rd;
   // a taken character occupies the shifter 15 cycles, so a second one waits in the holding register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {rv, tk, cnt, bsy, rd} <= '0;
      end else begin
         rv <= rx_go & ctl.rx_run;
         rd <= rx_in;
         tk <= 1'b0;
         if (ctl.tx_abort) begin
            {cnt, bsy} <= '0;
         end else if (bsy != 4'h0) begin
            bsy <= bsy - 4'h1;
         end else if (ctl.tx_run && ctl.tx_load_valid && !tk) begin
            cnt <= (cnt == delay) ? 4'h0 : cnt + 4'h1;
            tk  <= cnt == delay;
            bsy <= (cnt == delay) ? 4'hF : 4'h0;
         end
      end
   end
   assign evt = {rv, rd[7:0], rd[9], rd[8], tk, bsy != 4'h0, bsy != 4'h0 ? bsy[0] : idle_line};
endmodule
`default_nettype wire

/* tb/debug_uart_control_and_test_bench.sv */
// debug_uart_control_and_test_bench: self-checking bench for duct_top.
// assumes duct_far_end stands in for the engines; reads are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module debug_uart_control_and_test_bench;
   localparam logic [31:0] ID_V = 32'h0000_7E10; // arbitrary value, extension bit clear
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_dp, pin, out, rxq, txq;
   logic        dbg, cpu, irq, rx_go, idle_ln, tx_on;
   logic [31:0] haddr, hwdata, hrdata, dma_rdata, d;
   logic [1:0]  htrans;
   logic [9:0]  rx_in;
   logic [3:0]  rdi;
   duct_pkg::duct_eng_ctl_t    ec;
   duct_pkg::duct_eng_evt_t    ev;
   duct_pkg::duct_dma_status_t ds;
   duct_pkg::duct_dma_write_t  dw;
   logic [31:0] q[$];
   logic [11:0] za[12] = '{12'h0, 12'h4, 12'h8, 12'hC, 12'h10, 12'h14, 12'h18, 12'h1C, 12'h20, 12'h24, 12'h48, 12'hFC};
   logic [9:0]  ct[9] = '{10'h0C1, 10'h043, 10'h011, 10'h053, 10'h302, 10'h103, 10'h003, 10'h022, 10'h143};
   int          fail_count = 0;
   int          checks = 0;
   assign hready = hreadyout;
   duct_top #(.CHIP_IDENT_VALUE(ID_V)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .serial_in_pin(pin), .serial_out_pin(out), .eng_ctl(ec),
      .eng_evt(ev), .rx_dma_req(rxq), .tx_dma_req(txq), .dma_status(ds), .dma_rd_index(rdi),
      .dma_rdata(dma_rdata), .dma_write(dw), .dbg_to_cpu_pending(dbg), .cpu_to_dbg_pending(cpu), .irq(irq));
   duct_far_end far_u (.hclk(hclk), .hresetn(hresetn), .ctl(ec), .rx_go(rx_go), .rx_in(rx_in),
      .idle_line(idle_ln), .delay(4'h3), .evt(ev));
   task automatic chk(input logic [39:0] s, input logic [39:0] e);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 20'h0, a};
      do @(posedge hclk); while (!hready);
      {hsel, htrans, hwdata} <= {3'h0, v};
      if (!w) q.push_back(v);
      do @(posedge hclk); while (!hready);
      #1;
   endtask
   task automatic rxc(input logic [9:0] v);
      {rx_in, rx_go} <= {v, 1'b1};
      tick(1);
      rx_go <= 1'b0;
      tick(1);
   endtask
   function automatic logic [31:0] st(input logic r, input logic [2:0] e);
      return {dbg, cpu, 17'h0, ds.rx_buf_full, ds.tx_buf_empty, 1'b0, tx_on, 1'b0, e, ds.end_tx, ds.end_rx,
         1'b0, tx_on, r};
   endfunction
   task automatic end_of_test();
      if (fail_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge hclk) begin
      if (rd_dp) chk(hrdata, q.pop_front());
      rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
   end
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   initial begin
      #100000;
      fail_count++;
      end_of_test();
   end
   initial begin
      {hresetn, hsel, hwrite, dbg, cpu, rx_go, tx_on, htrans, ds, rx_in} = '0;
      {pin, idle_ln, haddr, hwdata, dma_rdata} = {2'h3, 96'h0};
      void'($urandom(3));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      tick(1);
      foreach (za[i]) bus(0, za[i], 32'h0);
      bus(1, 12'h010, $urandom);
      bus(0, 12'h010, 32'h0);
      bus(1, 12'h040, $urandom);
      bus(0, 12'h040, ID_V);
      bus(0, 12'h044, 32'h0);
      for (int i = 0; i < 8; i++) begin
         d = $urandom;
         bus(1, 12'h004, d);
         bus(0, 12'h004, d & 32'h0000_CE00);
         bus(1, 12'h020, d);
         bus(0, 12'h020, d & 32'h0000_FFFF);
         bus(1, 12'h004, {20'h0, i[2:0], 9'h0});
         chk(ec.parity, i[2] ? {1'b0, ec.parity[1:0]} : {1'b1, i[1:0]});
      end
      bus(1, 12'h000, 32'h50);
      foreach (ct[i]) begin
         bus(1, 12'h000, {24'h0, ct[i][9:2]});
         chk({ec.rx_run, ec.tx_run}, ct[i][1:0]);
      end
      tx_on = 1'b1;
      for (int m = 0; m < 4; m++) begin
         bus(1, 12'h004, {16'h0, m[1:0], 14'h0});
         repeat (3) begin
            {pin, idle_ln} <= 2'($urandom);
            tick(6);
            chk(out, m == 2 ? 1'b1 : m[0] ? pin : idle_ln);
            chk({ec.rx_line, m == 3 && (ec.rx_run | ec.tx_run)}, {m == 2 ? idle_ln : m == 3 ? 1'b1 : pin, 1'b0});
         end
      end
      bus(1, 12'h004, 32'h0);
      chk(txq, 1'b1);
      d = $urandom;
      bus(1, 12'h01C, d);
      chk({txq, ec.tx_data}, {1'b0, d[7:0]});
      for (int i = 0; i < 30 && !txq; i++) tick(1);
      chk({txq, ec.tx_load_valid}, 2'b10);
      bus(1, 12'h01C, ~d);
      bus(1, 12'h000, 32'h08);
      chk({txq, ec.tx_load_valid, ec.tx_run}, 3'b000);
      bus(1, 12'h000, 32'h40);
      chk(txq, 1'b1);
      rxc(10'h2A5);
      chk(rxq, 1'b1);
      bus(0, 12'h014, st(1'b1, 3'b100));
      bus(0, 12'h018, 32'hA5);
      chk(rxq, 1'b0);
      rxc(10'h03C);
      rxc(10'h15A);
      bus(0, 12'h014, st(1'b1, 3'b111));
      bus(1, 12'h000, 32'h100);
      repeat (3) begin
         {ds, dbg, cpu} <= 6'($urandom);
         tick(1);
         bus(0, 12'h014, st(1'b1, 3'b000));
      end
      bus(0, 12'h018, 32'h5A);
      dbg <= 1'b1;
      bus(1, 12'h008, 32'h8000_0000);
      bus(0, 12'h010, 32'h8000_0000);
      chk(irq, 1'b1);
      bus(1, 12'h00C, 32'h8000_0000);
      tick(2);
      chk({irq, hresp, hreadyout}, 3'b001);
      d = $urandom;
      dma_rdata <= d;
      bus(1, 12'h104, d);
      chk(dw, {1'b1, 4'h1, d});
      bus(0, 12'h108, d);
      chk(rdi, 4'h2);
      end_of_test();
   end
endmodule
bind duct_top duct_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .serial_in_pin(serial_in_pin),
   .serial_out_pin(serial_out_pin), .eng_ctl(eng_ctl), .eng_evt(eng_evt), .rx_dma_req(rx_dma_req),
   .tx_dma_req(tx_dma_req));
`default_nettype wire
